// ===== hdl/flash_host.sv
// host controller driving a boot-sector flash through its pins
//
// Overview of operation
// - high-voltage A9, A6/A1 low, A0 picks code
// - protection check: sector bits, A1 high, A0 low
// - identification codes readable after command, no high-voltage
// - protection changes only via high-voltage equipment
// - unlock cycles precede every program or erase
// - host holds controls inactive around lockout
// - two unlocks plus identify command enter mode
// - reset command leaves identification mode
module flash_host
    import flash_host_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // user request
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [17:0] op_addr,
    input wire logic [7:0] op_data,
    input wire logic [1:0] id_sel,
    input wire logic boot_top,
    input wire logic unprotect_req,
    input wire logic supply_ok,
    // user answer
    output logic op_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic [2:0] rsp_sector,
    output logic unprotect_active,
    // flash pins
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    output logic [17:0] flash_addr,
    output logic [7:0] flash_data_out,
    output logic flash_data_oe_n,
    input wire logic [7:0] flash_data_in,
    // high-voltage qualifiers
    output logic a9_high_voltage,
    output logic reset_high_voltage
);
    localparam logic [7:0] CNT_READ = 8'(`CYC_READ - 1);
    localparam logic [7:0] CNT_WRITE = 8'(`CYC_WRITE - 1);
    localparam logic [7:0] CNT_RECOVER = 8'(`CYC_RECOVER - 1);
    localparam logic [7:0] CNT_HV = 8'(`CYC_HV_SETTLE - 1);

    host_state_t s;
    host_state_t next_s;
    logic rst_b_q;
    bus_cyc_t cyc;
    sector_if sif ();

    // sector lookup on the latched address
    assign sif.addr_hi = s.addr[17:`SECTOR_LSB];
    assign sif.boot_top = boot_top;

    sector_map u_sector_map (
        .sif(sif.map)
    );

    // bus cycle of the current sequence step
    always_comb begin
        cyc = '{we: 1'b1, last: 1'b0, addr: `UNLOCK_ADDR1, data: `UNLOCK_DATA1};
        case (s.op)
            OP_READ: begin
                cyc = '{we: 1'b0, last: 1'b1, addr: s.addr, data: 8'h00};
            end
            OP_PROGRAM: begin
                case (s.step)
                    3'h0: cyc.data = `UNLOCK_DATA1;
                    3'h1: cyc = '{we: 1'b1, last: 1'b0, addr: `UNLOCK_ADDR2, data: `UNLOCK_DATA2};
                    3'h2: cyc.data = `CMD_PROGRAM;
                    default: cyc = '{we: 1'b1, last: 1'b1, addr: s.addr, data: s.data};
                endcase
            end
            OP_ERASE: begin
                case (s.step)
                    3'h0, 3'h3: cyc.data = `UNLOCK_DATA1;
                    3'h1, 3'h4: begin
                        cyc = '{we: 1'b1, last: 1'b0, addr: `UNLOCK_ADDR2, data: `UNLOCK_DATA2};
                    end
                    3'h2: cyc.data = `CMD_ERASE_SETUP;
                    default: begin
                        cyc.last = 1'b1;
                        cyc.addr = {sif.base_hi, 13'h0000};
                        cyc.data = `CMD_SECTOR_ERASE;
                    end
                endcase
            end
            OP_ID_ENTER: begin
                case (s.step)
                    3'h0: cyc.data = `UNLOCK_DATA1;
                    3'h1: cyc = '{we: 1'b1, last: 1'b0, addr: `UNLOCK_ADDR2, data: `UNLOCK_DATA2};
                    default: begin
                        cyc.last = 1'b1;
                        cyc.data = `CMD_ID_ENTER;
                    end
                endcase
            end
            OP_ID_READ, OP_HV_ID_READ: begin
                cyc.we = 1'b0;
                cyc.last = 1'b1;
                cyc.data = 8'h00;
                cyc.addr = {s.addr[17:`SECTOR_LSB], 13'h0000};
                // A6 stays low; A1/A0 choose maker, part or protection
                if (s.id_sel == `ID_SEL_PROTECT) begin
                    cyc.addr[1:0] = `ID_PROTECT_LOW;
                end else begin
                    cyc.addr[1:0] = {1'b0, s.id_sel[0]};
                end
                cyc.addr[`HV_A6_BIT] = 1'b0;
            end
            default: begin
                cyc.last = 1'b1;
                cyc.data = `CMD_RESET;
            end
        endcase
    end

    // next-state logic of the bus engine
    always_comb begin
        next_s = s;
        next_s.rsp_valid = 1'b0;
        case (s.st)
            S_IDLE: begin
                next_s.ce_n = 1'b1;
                next_s.oe_n = 1'b1;
                next_s.we_n = 1'b1;
                next_s.fd_oe_n = 1'b1;
                next_s.a9_hv = 1'b0;
                // unprotect level follows request only between operations
                next_s.rst_hv = unprotect_req & `HAS_RESET_PIN & supply_ok;
                next_s.ready = supply_ok;
                if (op_valid && s.ready && supply_ok) begin
                    next_s.ready = 1'b0;
                    next_s.op = op_t'(op_code);
                    next_s.addr = op_addr;
                    next_s.data = op_data;
                    next_s.id_sel = id_sel;
                    next_s.step = 3'h0;
                    next_s.st = S_SETUP;
                    next_s.cnt = 8'h00;
                    if (op_t'(op_code) == OP_HV_ID_READ) begin
                        next_s.a9_hv = 1'b1;
                        next_s.cnt = CNT_HV;
                    end
                end
            end
            S_SETUP: begin
                // address, chip enable and write data on the same edge as the strobe, ahead of it only in a high-voltage read
                next_s.ce_n = 1'b0;
                next_s.fa = cyc.addr;
                next_s.fd = cyc.data;
                next_s.fd_oe_n = ~cyc.we;
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else begin
                    next_s.st = S_STROBE;
                    next_s.we_n = ~cyc.we;
                    next_s.oe_n = cyc.we;
                    next_s.cnt = cyc.we ? CNT_WRITE : CNT_READ;
                end
            end
            S_STROBE: begin
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else begin
                    // sample read data at the end of the output gate pulse
                    next_s.rsp_data = cyc.we ? 8'h00 : flash_data_in;
                    next_s.we_n = 1'b1;
                    next_s.oe_n = 1'b1;
                    next_s.st = S_HOLD;
                    next_s.cnt = CNT_RECOVER;
                end
            end
            S_HOLD: begin
                next_s.ce_n = 1'b1;
                next_s.fd_oe_n = 1'b1;
                if (s.cnt != 8'h00) begin
                    next_s.cnt = s.cnt - 8'h01;
                end else if (cyc.last) begin
                    next_s.st = S_IDLE;
                    next_s.a9_hv = 1'b0;
                    next_s.rsp_valid = 1'b1;
                    next_s.rsp_sector = sif.sector;
                end else begin
                    next_s.step = s.step + 3'h1;
                    next_s.st = S_SETUP;
                end
            end
            default: begin
                next_s.st = S_IDLE;
            end
        endcase
        // below lockout every control drops inactive and the sequence aborts
        if (!supply_ok) begin
            next_s.st = S_IDLE;
            next_s.ready = 1'b0;
            next_s.ce_n = 1'b1;
            next_s.oe_n = 1'b1;
            next_s.we_n = 1'b1;
            next_s.fd_oe_n = 1'b1;
            next_s.a9_hv = 1'b0;
            next_s.rst_hv = 1'b0;
            next_s.rsp_valid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= S_IDLE;
            s.op <= OP_READ;
            s.ce_n <= 1'b1;
            s.oe_n <= 1'b1;
            s.we_n <= 1'b1;
            s.fd_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register, flash reset pin from its own flop
    assign op_ready = s.ready;
    assign rsp_valid = s.rsp_valid;
    assign rsp_data = s.rsp_data;
    assign rsp_sector = s.rsp_sector;
    assign unprotect_active = s.rst_hv;
    assign flash_ce_n = s.ce_n;
    assign flash_oe_n = s.oe_n;
    assign flash_we_n = s.we_n;
    assign flash_reset_n = rst_b_q;
    assign flash_addr = s.fa;
    assign flash_data_out = s.fd;
    assign flash_data_oe_n = s.fd_oe_n;
    assign a9_high_voltage = s.a9_hv;
    assign reset_high_voltage = s.rst_hv;

    // flash reset pin released one edge after controller reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_b_q <= 1'b0;
        end else begin
            rst_b_q <= 1'b1;
        end
    end
endmodule

// ===== shared/flash_host_defs.svh
// timing counts, pin constants and command codes for the flash host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

// clock rate and bus timing
`define CLK_MHZ 25
`define T_READ_NS 90
`define T_WRITE_NS 45
`define T_RECOVER_NS 20
`define T_HV_SETTLE_NS 4000
`define CYC_MIN(ns) (((ns) * `CLK_MHZ + 999) / 1000)
`define CYC_READ `CYC_MIN(`T_READ_NS)
`define CYC_WRITE `CYC_MIN(`T_WRITE_NS)
`define CYC_RECOVER `CYC_MIN(`T_RECOVER_NS)
`define CYC_HV_SETTLE `CYC_MIN(`T_HV_SETTLE_NS)

// variant strap: 1 when the part has the hardware reset pin
`define HAS_RESET_PIN 1'b1

// unlock cycle addresses and data
`define UNLOCK_ADDR1 18'h00555
`define UNLOCK_ADDR2 18'h002AA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55

// command bytes
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_ID_ENTER 8'h90
`define CMD_RESET 8'hF0

// identification read low address bits
`define ID_SEL_MAKER 2'h0
`define ID_SEL_PART 2'h1
`define ID_SEL_PROTECT 2'h2
`define ID_PROTECT_LOW 2'h2

// address field positions
`define SECTOR_LSB 13
`define HV_A6_BIT 6

`endif

// ===== shared/flash_host_pkg.sv
// types for the flash host controller
package flash_host_pkg;
`include "flash_host_defs.svh"

    // user operations
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_ID_ENTER = 3'h3,
        OP_ID_READ = 3'h4,
        OP_RESET = 3'h5,
        OP_HV_ID_READ = 3'h6
    } op_t;

    // bus engine states, one-hot
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SETUP = 4'h2,
        S_STROBE = 4'h4,
        S_HOLD = 4'h8
    } state_t;

    // one bus cycle of a command sequence
    typedef struct packed {
        logic we;
        logic last;
        logic [17:0] addr;
        logic [7:0] data;
    } bus_cyc_t;

    // whole controller state
    typedef struct packed {
        state_t st;
        logic [7:0] cnt;
        logic [2:0] step;
        op_t op;
        logic [17:0] addr;
        logic [7:0] data;
        logic [1:0] id_sel;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [17:0] fa;
        logic [7:0] fd;
        logic fd_oe_n;
        logic a9_hv;
        logic rst_hv;
        logic ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic [2:0] rsp_sector;
    } host_state_t;
endpackage

// ===== shared/sector_if.sv
// sector lookup link between the controller and its sector map
interface sector_if;
    logic [4:0] addr_hi;
    logic boot_top;
    logic [2:0] sector;
    logic [4:0] base_hi;

    modport map (input addr_hi, input boot_top, output sector, output base_hi);
    modport user (output addr_hi, output boot_top, input sector, input base_hi);
endinterface

// ===== hdl/sector_map.sv
// sector decode for top-boot and bottom-boot arrangements
module sector_map (
    // lookup link
    sector_if.map sif
);
    // address bits 17..13 to sector number and sector base bits
    always_comb begin
        sif.sector = 3'h0;
        sif.base_hi = 5'h00;
        if (sif.boot_top) begin
            case (sif.addr_hi[4:3])
                2'b00: sif.sector = 3'h0;
                2'b01: sif.sector = 3'h1;
                2'b10: sif.sector = 3'h2;
                default: begin
                    if (!sif.addr_hi[2]) begin
                        sif.sector = 3'h3;
                    end else if (sif.addr_hi[1]) begin
                        sif.sector = 3'h6;
                    end else begin
                        sif.sector = sif.addr_hi[0] ? 3'h5 : 3'h4;
                    end
                end
            endcase
            case (sif.sector)
                3'h0: sif.base_hi = 5'h00;
                3'h1: sif.base_hi = 5'h08;
                3'h2: sif.base_hi = 5'h10;
                3'h3: sif.base_hi = 5'h18;
                3'h4: sif.base_hi = 5'h1C;
                3'h5: sif.base_hi = 5'h1D;
                default: sif.base_hi = 5'h1E;
            endcase
        end else begin
            case (sif.addr_hi[4:3])
                2'b11: sif.sector = 3'h6;
                2'b10: sif.sector = 3'h5;
                2'b01: sif.sector = 3'h4;
                default: begin
                    if (sif.addr_hi[2]) begin
                        sif.sector = 3'h3;
                    end else if (!sif.addr_hi[1]) begin
                        sif.sector = 3'h0;
                    end else begin
                        sif.sector = sif.addr_hi[0] ? 3'h2 : 3'h1;
                    end
                end
            endcase
            case (sif.sector)
                3'h0: sif.base_hi = 5'h00;
                3'h1: sif.base_hi = 5'h02;
                3'h2: sif.base_hi = 5'h03;
                3'h3: sif.base_hi = 5'h04;
                3'h4: sif.base_hi = 5'h08;
                3'h5: sif.base_hi = 5'h10;
                default: sif.base_hi = 5'h18;
            endcase
        end
    end
endmodule

// ===== tb/flash_host_props.sv
// concurrent checks on the flash host controller ports
module flash_host_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // user side
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic supply_ok,
    input wire logic unprotect_req,
    input wire logic op_ready,
    input wire logic rsp_valid,
    input wire logic unprotect_active,
    // flash pins
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [17:0] flash_addr,
    input wire logic flash_data_oe_n,
    input wire logic a9_high_voltage,
    input wire logic reset_high_voltage
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // request accepted at this edge
    wire take = op_valid && op_ready && supply_ok;

    AST_RDY_DROP: assert property (take |=> !op_ready)
        else $error("ready still high after a take");
    AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer strobe longer than one cycle");
    AST_RDY_BACK: assert property (rsp_valid && supply_ok |=> op_ready)
        else $error("ready not back after answer");
    AST_READ_LAT: assert property (take && op_code == 3'h0 ##1 supply_ok [*5] |=> rsp_valid)
        else $error("read answer not on cycle six");
    AST_GATE_DRIVE: assert property (!flash_oe_n |-> flash_data_oe_n)
        else $error("host drives data while output gate low");
    AST_WRITE_FORM: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_data_oe_n)
        else $error("write strobe outside a write cycle");
    AST_LOCKOUT: assert property (!supply_ok |=> flash_we_n && flash_ce_n && !op_ready
        && !a9_high_voltage && !reset_high_voltage)
        else $error("controls active below lockout");
    AST_UNPROT_SAME: assert property (unprotect_active == reset_high_voltage)
        else $error("unprotect flag differs from qualifier");
    AST_UNPROT_FOLLOW: assert property (op_ready && !op_valid && supply_ok
        |=> reset_high_voltage == $past(unprotect_req))
        else $error("reset pin qualifier not following request");
    AST_HV_A6: assert property (a9_high_voltage && !flash_oe_n |-> !flash_addr[6])
        else $error("high-voltage read with address bit 6 high");
    AST_NO_HV: assert property (take && op_code inside {3'h1, 3'h2, 3'h4}
        |=> !a9_high_voltage [*8])
        else $error("address qualifier raised in a command op");
endmodule

bind flash_host flash_host_props u_props (.*);

// ===== tb/flash_dev_model.sv
// behavioural boot-sector flash device seen from its pins
module flash_dev_model #(
    parameter logic [7:0] MAKER = 8'h5A,
    parameter logic [7:0] PART_TOP = 8'hC3,
    parameter logic [7:0] PART_BOT = 8'h6E,
    parameter bit HAS_RST = 1'b1
) (
    // control pins
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    // address and data
    input wire logic [17:0] a,
    input wire logic [7:0] d,
    output logic [7:0] q,
    // qualifiers and straps
    input wire logic a9_hv,
    input wire logic rst_hv,
    input wire logic top,
    input wire logic vcc_ok
);
    logic [7:0] mem [0:262143];
    logic [6:0] prot = 7'h0;
    logic idm = 1'b0;
    logic [7:0] rdv = 8'h00;
    int st = 0;

    // start address of sector i, entry 7 is the end of space
    function automatic int base(int i, logic t);
        int tb [8] = '{19'h0, 19'h10000, 19'h20000, 19'h30000, 19'h38000, 19'h3A000,
            19'h3C000, 19'h40000};
        int bb [8] = '{19'h0, 19'h4000, 19'h6000, 19'h8000, 19'h10000, 19'h20000,
            19'h30000, 19'h40000};
        return t ? tb[i] : bb[i];
    endfunction
    function automatic int sec_of(int x, logic t);
        int s = 0;
        for (int i = 1; i < 7; i++) if (x >= base(i, t)) s = i;
        return s;
    endfunction
    // protection lifted only while the reset pin sits at high voltage
    function automatic bit open_sec(int x);
        return !prot[sec_of(x, top)] || (HAS_RST && rst_hv);
    endfunction

    initial foreach (mem[i]) mem[i] = 8'hFF;
    // supply drop or reset pin clears the command state
    always @(negedge vcc_ok or negedge reset_n) begin
        st = 0;
        idm = 1'b0;
    end
    // command decode on the rising edge of the write strobe
    always @(posedge we_n) begin
        if (!ce_n && vcc_ok && reset_n) begin
            if (st == 6) begin
                if (open_sec(a)) mem[a] = mem[a] & d;
                st = 0;
            end else if (st == 5 && d == 8'h30) begin : ers
                int s;
                s = sec_of(a, top);
                if (open_sec(a))
                    for (int i = base(s, top); i < base(s + 1, top); i++) mem[i] = 8'hFF;
                st = 0;
            end else if (d == 8'hF0) begin
                idm = 1'b0;
                st = 0;
            end else begin
                case (st)
                    0: st = d == 8'hAA ? 1 : 0;
                    1: st = d == 8'h55 ? 2 : 0;
                    2: begin
                        idm = idm | (d == 8'h90);
                        st = d == 8'hA0 ? 6 : d == 8'h80 ? 3 : 0;
                    end
                    3: st = d == 8'hAA ? 4 : 0;
                    4: st = d == 8'h55 ? 5 : 0;
                    default: st = 0;
                endcase
            end
        end
    end
    // read value taken as the output gate opens, again if the address moves with it
    always @(negedge oe_n or a) begin
        if (!oe_n) begin
            if (idm || (a9_hv && !a[6])) begin
                case (a[1:0])
                    2'h0: rdv = MAKER;
                    2'h1: rdv = top ? PART_TOP : PART_BOT;
                    default: rdv = {7'h0, prot[sec_of(a, top)]};
                endcase
            end else begin
                rdv = mem[a];
            end
        end
    end
    // released lines show the inverse of the last byte
    assign q = (!ce_n && !oe_n && reset_n) ? rdv : ~rdv;
endmodule

// ===== tb/flash_host_tb.sv
// self-checking bench for the flash host controller
module flash_host_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // identity codes, values arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5A;
    localparam logic [7:0] PART_T = 8'hC3;
    localparam logic [7:0] PART_B = 8'h6E;
    // design inputs
    logic clk_sys = 1'b0, rst_b = 1'b0, op_valid = 1'b0, boot_top = 1'b1;
    logic unprotect_req = 1'b0, supply_ok = 1'b1;
    logic [2:0] op_code = 3'h0;
    logic [17:0] op_addr = 18'h0;
    logic [7:0] op_data = 8'h0;
    logic [1:0] id_sel = 2'h0;
    // design outputs
    logic op_ready, rsp_valid, unprotect_active, flash_ce_n, flash_oe_n, flash_we_n;
    logic flash_reset_n, flash_data_oe_n, a9_high_voltage, reset_high_voltage;
    logic [7:0] rsp_data, flash_data_out, flash_data_in;
    logic [2:0] rsp_sector;
    logic [17:0] flash_addr;
    // reference contents and protection
    logic [7:0] ref_mem [0:262143];
    logic [6:0] ref_prot = 7'h0;
    int num_errors = 0, checks_done = 0, a, n;

    always #20 clk_sys = ~clk_sys;

    flash_host DUT (.*);
    flash_dev_model #(.MAKER(MAKER_ID), .PART_TOP(PART_T), .PART_BOT(PART_B)) u_dev (
        .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .reset_n(flash_reset_n),
        .a(flash_addr), .d(flash_data_out), .q(flash_data_in), .a9_hv(a9_high_voltage),
        .rst_hv(reset_high_voltage), .top(boot_top), .vcc_ok(supply_ok));

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        num_errors++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask
    function automatic int sbase(int i);
        return u_dev.base(i, boot_top);
    endfunction
    // request held until taken, then wait for its answer
    task automatic run_op(input logic [2:0] c, input int ad, input logic [7:0] d,
        input logic [1:0] s);
        int k = 0;
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = c;
        op_addr = ad[17:0];
        op_data = d;
        id_sel = s;
        while (op_ready !== 1'b1) begin
            @(negedge clk_sys);
            if (++k > 60) hang();
        end
        @(negedge clk_sys);
        op_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1) begin
            @(negedge clk_sys);
            if (++k > 300) hang();
        end
    endtask
    // reference update only where the sector is open
    task automatic prog(input int ad, input logic [7:0] d);
        bit o = !ref_prot[u_dev.sec_of(ad, boot_top)] || unprotect_req;
        run_op(3'h1, ad, d, 2'h0);
        if (o) ref_mem[ad] = ref_mem[ad] & d;
    endtask
    task automatic erase(input int ad);
        int s = u_dev.sec_of(ad, boot_top);
        bit o = !ref_prot[s] || unprotect_req;
        run_op(3'h2, ad, 8'h0, 2'h0);
        if (o) for (int k = sbase(s); k < sbase(s + 1); k++) ref_mem[k] = 8'hFF;
    endtask
    task automatic rd(input int ad);
        run_op(3'h0, ad, 8'h0, 2'h0);
        chk(rsp_data, ref_mem[ad]);
        chk({5'h0, rsp_sector}, 8'(u_dev.sec_of(ad, boot_top)));
    endtask
    // protection of each sector, then maker and part codes
    task automatic idr(input logic [2:0] c);
        logic [7:0] exp;
        for (int s = 0; s < 9; s++) begin
            run_op(c, s < 7 ? sbase(s) : 0, 8'h0, s < 7 ? 2'h2 : 2'(s - 7));
            exp = s < 7 ? {7'h0, ref_prot[s]} : s == 7 ? MAKER_ID : boot_top ? PART_T : PART_B;
            chk(rsp_data, exp);
        end
    endtask

    initial begin
        void'($urandom(32'h48A5C7E3));
        foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
        // both boot arrangements, each after a fresh reset
        for (int t = 1; t >= 0; t--) begin
            rst_b = 1'b0;
            boot_top = t[0];
            repeat (20) @(negedge clk_sys);
            rst_b = 1'b1;
            run_op(3'h3, 0, 8'h0, 2'h0);
            repeat (2) idr(3'h4);
            run_op(3'h5, 0, 8'h0, 2'h0);
            for (int s = 0; s < 7; s++) begin
                a = sbase(s) + $urandom_range(sbase(s + 1) - sbase(s) - 1);
                prog(a, 8'($urandom));
                rd(a);
                rd(sbase(s));
                rd(sbase(s + 1) - 1);
            end
        end
        // sector protected beforehand by equipment
        u_dev.prot[5] = 1'b1;
        ref_prot[5] = 1'b1;
        idr(3'h6);
        a = sbase(5) + 3;
        prog(a, 8'h00);
        rd(a);
        erase(a);
        rd(a);
        unprotect_req = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({7'h0, reset_high_voltage}, 8'h01);
        prog(a, 8'h0F);
        rd(a);
        unprotect_req = 1'b0;
        repeat (4) @(negedge clk_sys);
        prog(a, 8'h00);
        rd(a);
        erase(sbase(6));
        rd(sbase(6) + 5);
        // supply drop in the middle of a program sequence
        a = sbase(4);
        run_op(3'h0, a, 8'h0, 2'h0);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = 3'h1;
        op_addr = a[17:0];
        @(negedge clk_sys);
        op_valid = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({7'h0, op_ready}, 8'h00);
        supply_ok = 1'b0;
        n = 0;
        repeat (30) @(negedge clk_sys) n += rsp_valid;
        chk(8'(n), 8'h00);
        chk({7'h0, op_ready}, 8'h00);
        supply_ok = 1'b1;
        rd(a);
        print_verdict();
    end
endmodule
